/* File: verilog/ext_irq_wakeup_logic.v */
// Register access is over AXI4-Lite, implemented in this module.
`include "wake_regs.vh"

// ======================================================
// notes for integrators
// the pins are sampled on sys_clk, so this block only
// sees a wake level while sys_clk still runs; a design
// that gates sys_clk in power-down must keep this block
// on an ungated branch of the clock tree
// a pin level must stand for two cycles before it
// is acted on; single-cycle pulses are treated as noise
// the wake flags and the interrupt status are separate
// copies: software may poll one and route the other to
// the interrupt controller without the two interfering

module ext_irq_wakeup_logic #(
  parameter ADDR_W = 32
) (
  input wire sys_clk, // system clock, 40 MHz
  input wire rst_n, // synchronous reset, active low
  input wire ext_request_pin_a, // first request pin, async
  input wire ext_request_pin_b, // second request pin, async
  input wire power_down_active, // chip is in power-down
  output reg wake_request, // starts clock recovery
  output reg irq, // level interrupt, status masked by the mask register
  input wire [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [ADDR_W-1:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready // read data ready
);

  // ======================================================
  // declarations
  // pin conditioning
  wire [1:0] pin_raw;
  reg [1:0] sync1_reg;
  reg [1:0] sync2_reg;
  reg [1:0] sync3_reg;
  reg [1:0] pin_level_reg;
  wire [1:0] pin_en;
  wire [1:0] pin_lvl;
  wire [1:0] pin_match;
  wire [1:0] wake_event;
  // register file
  reg [5:0] control_reg;
  reg [5:0] control_next;
  reg [1:0] flags_reg;
  reg [1:0] flags_next;
  reg [1:0] status_reg;
  reg [1:0] status_next;
  reg [1:0] mask_reg;
  reg [1:0] mask_next;
  // bus capture
  reg [ADDR_W-1:0] awaddr_reg;
  reg aw_held_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_held_reg;
  wire do_write;
  wire wr_lane0;
  reg wr_hit;
  reg [31:0] rd_word;
  reg rd_hit;

  assign pin_raw = {ext_request_pin_b, ext_request_pin_a};

  // ======================================================
  // per-pin input conditioning and wake match
  // latency from a pin change to wake_request: one edge
  // per stage, one for the agreement check and one for the
  // registered output, so about five edges in all
  // the pins idle high, so for a few cycles after reset
  // the filtered level reads low; control resets to all
  // disabled, which keeps that from raising a wake
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      // three stages; only the second and third are compared
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end

      // a change is accepted once two stages agree, which
      // rejects a single-cycle glitch at the cost of a cycle
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          pin_level_reg[gi] <= 1'b0;
        end else if (sync2_reg[gi] == sync3_reg[gi]) begin
          pin_level_reg[gi] <= sync3_reg[gi];
        end
      end

      // level 1 wakes on high, level 0 wakes on low
      assign pin_match[gi] = pin_en[gi] &
        (pin_level_reg[gi] == pin_lvl[gi]);
      // only while powered down does a match count as wake
      assign wake_event[gi] = pin_match[gi] &
        power_down_active;
    end
  endgenerate

  // ======================================================
  // control field taps
  // reserved control bits 2, 3 and 6 up are not stored
  assign pin_en[0] = control_reg[`CTL_EN_A];
  assign pin_en[1] = control_reg[`CTL_EN_B];
  assign pin_lvl[0] = control_reg[`CTL_LVL_A];
  assign pin_lvl[1] = control_reg[`CTL_LVL_B];

  // ======================================================
  // wake request toward the clock recovery logic
  // held as a level so recovery sees it even if slow
  // it drops one edge after the match ends or power-down
  // ends, so recovery must latch it if it needs a pulse
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= |wake_event;
    end
  end

  // ======================================================
  // bus write channel: address and data taken in any order
  // awready and wready fall on their own handshake and
  // only rise again with the write response; this caps
  // the bus at one write in flight, which keeps the
  // register update and the response in lockstep
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_lane0 = wstrb_reg[0];

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      aw_held_reg <= 1'b0;
      awaddr_reg <= {ADDR_W{1'b0}};
    end else if (s_axi_awvalid & s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_held_reg <= 1'b0;
    end
  end

  // data side mirrors the address side
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b1;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_held_reg <= 1'b0;
    end
  end

  // address decode for writes
  always @* begin
    case (awaddr_reg)
      `ADDR_WAKE_CONTROL: wr_hit = 1'b1;
      `ADDR_WAKE_FLAGS: wr_hit = 1'b1;
      `ADDR_IRQ_STATUS: wr_hit = 1'b1;
      `ADDR_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // response follows once both halves are in
  // an unmapped address is still answered, with an error,
  // so a stray write can never hang the bus
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ======================================================
  // register next values
  // all fields sit in byte lane 0, other lanes are ignored
  // a write with lane 0 disabled is answered okay but
  // changes nothing, since no field lives above bit 7
  always @* begin
    control_next = control_reg;
    mask_next = mask_reg;
    if (do_write & wr_lane0) begin
      if (awaddr_reg == `ADDR_WAKE_CONTROL) begin
        control_next = {wdata_reg[`CTL_LVL_B],
          wdata_reg[`CTL_LVL_A], 2'b00,
          wdata_reg[`CTL_EN_B], wdata_reg[`CTL_EN_A]};
      end
      if (awaddr_reg == `ADDR_IRQ_MASK) begin
        mask_next = wdata_reg[`FLAG_W-1:0];
      end
    end
  end

  // wake flags: a written zero clears, a wake event sets;
  // the set wins if both land in the same cycle
  always @* begin
    flags_next = flags_reg;
    if (do_write & wr_lane0 &
        (awaddr_reg == `ADDR_WAKE_FLAGS)) begin
      flags_next = flags_reg & wdata_reg[`FLAG_W-1:0];
    end
    flags_next = flags_next | wake_event;
  end

  // interrupt status: write one to clear, set wins
  // status uses write-one-to-clear while the wake flags
  // use write-zero-to-clear; the two are kept apart so a
  // handler can acknowledge the interrupt without losing
  // the record of which pin woke the chip
  always @* begin
    status_next = status_reg;
    if (do_write & wr_lane0 &
        (awaddr_reg == `ADDR_IRQ_STATUS)) begin
      status_next = status_reg & ~wdata_reg[`FLAG_W-1:0];
    end
    status_next = status_next | wake_event;
  end

  // ======================================================
  // register state
  // one process holds control, flags, status and mask so reset is uniform
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      control_reg <= `RST_CONTROL;
      flags_reg <= `RST_FLAGS;
      status_reg <= `RST_FLAGS;
      mask_reg <= `RST_MASK;
    end else begin
      control_reg <= control_next;
      flags_reg <= flags_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
    end
  end

  // ======================================================
  // interrupt output, registered from next state so it
  // tracks status and mask with no extra cycle of lag
  // masking a set status bit drops irq at the same edge
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & mask_next);
    end
  end

  // ======================================================
  // bus read channel
  // reads never stall writes and writes never stall
  // reads; a read that races a write returns the value
  // from before the write's update edge
  // read data mux; reserved bits read as zero
  always @* begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `ADDR_WAKE_CONTROL: begin
        rd_word[`CTL_EN_A] = control_reg[`CTL_EN_A];
        rd_word[`CTL_EN_B] = control_reg[`CTL_EN_B];
        rd_word[`CTL_LVL_A] = control_reg[`CTL_LVL_A];
        rd_word[`CTL_LVL_B] = control_reg[`CTL_LVL_B];
      end
      `ADDR_WAKE_FLAGS: begin
        rd_word[`FLAG_W-1:0] = flags_reg;
      end
      `ADDR_IRQ_STATUS: begin
        rd_word[`FLAG_W-1:0] = status_reg;
      end
      `ADDR_IRQ_MASK: begin
        rd_word[`FLAG_W-1:0] = mask_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // one read at a time; data is captured on the address
  // handshake so it stays stable while rready is low
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ext_irq_wakeup_logic

/* File: common/wake_regs.vh */
`ifndef WAKE_REGS_VH
`define WAKE_REGS_VH
// ======================================================
// register byte addresses
`define ADDR_WAKE_CONTROL 32'hFFF00020
`define ADDR_WAKE_FLAGS 32'hFFF00024
`define ADDR_IRQ_STATUS 32'hFFF00028
`define ADDR_IRQ_MASK 32'hFFF0002C
// ======================================================
// wake control fields
`define CTL_EN_A 0
`define CTL_EN_B 1
`define CTL_LVL_A 4
`define CTL_LVL_B 5
// ======================================================
// flag, status and mask fields share one layout
`define FLAG_PIN_A 0
`define FLAG_PIN_B 1
`define FLAG_W 2
// ======================================================
// reset values
`define RST_CONTROL 6'h00
`define RST_FLAGS 2'h0
`define RST_MASK 2'h0
// ======================================================
// bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: sim/ext_irq_wakeup_logic_asserts.sv */
// ======================================================
// bus and wake checks, ports only
module ext_irq_wakeup_logic_asserts (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // reset, low
  input wire logic power_down_active, // pd
  input wire logic wake_request, // wake out
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  property p_idle_no_wake;
    !power_down_active |=> !wake_request;
  endproperty
  a_idle_no_wake: assert property (p_idle_no_wake)
    else $error("wake outside power-down");
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("write response late");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read data late");
  property p_w_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy)
    else $error("write taken while response pending");
  property p_r_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_busy: assert property (p_r_busy)
    else $error("read taken while data pending");
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("reserved read bits set");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done)
    else $error("read data repeated");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("write response repeated");
endmodule // ext_irq_wakeup_logic_asserts

bind ext_irq_wakeup_logic ext_irq_wakeup_logic_asserts chk_u (
  .sys_clk, .rst_n, .power_down_active, .wake_request,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

/* File: sim/irq_source_model.sv */
// ======================================================
// external sources: hold each pin at the commanded level
module irq_source_model (
  input wire logic lvl_a, // commanded level a
  input wire logic lvl_b, // commanded level b
  output logic pin_a, // first pin
  output logic pin_b // second pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // levels are held steady, never pulsed, so the sync sees them
  assign pin_a = lvl_a;
  assign pin_b = lvl_b;
endmodule // irq_source_model

/* File: sim/ext_irq_wakeup_logic_tb.sv */
`include "wake_regs.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  err_total++; $display("Error at %0t: got %h exp %h", $time, a, b); end end
module ext_irq_wakeup_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_n = 0, pd = 0, la = 1, lb = 1, done;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rv;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] rs;
  wire pa, pb, wake, irq, awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int err_total = 0, comparisons = 0;
  // ======================================================
  // clock, parts
  always #12.5 sys_clk = ~sys_clk;
  irq_source_model src_u (.lvl_a(la), .lvl_b(lb), .pin_a(pa), .pin_b(pb));
  ext_irq_wakeup_logic dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .ext_request_pin_a(pa), .ext_request_pin_b(pb),
    .power_down_active(pd), .wake_request(wake), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ======================================================
  // bus tasks: each channel released at its own handshake edge
  task wr(input logic [31:0] a, d);
    done = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        rs = bresp;
        bready <= 0;
        done = 1;
      end
    end
  endtask
  task rd(input logic [31:0] a);
    done = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        rv = rdata;
        rs = rresp;
        rready <= 0;
        done = 1;
      end
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // ======================================================
  // scenarios
  task t_reset;
    for (int i = 0; i < 4; i++) begin
      rd(32'hFFF00020 + 4 * i);
      `CHK(rv, 32'h00000000)
    end
    rd(32'hFFF00030);
    `CHK(rs, `RESP_SLVERR)
    wr(32'hFFF00030, 32'hFFFFFFFF);
    `CHK(rs, `RESP_SLVERR)
    wr(`ADDR_WAKE_CONTROL, 32'hFFFFFFFF);
    rd(`ADDR_WAKE_CONTROL);
    `CHK(rv, 32'h00000033)
    wr(`ADDR_WAKE_CONTROL, 32'h00000000);
  endtask
  // matching level with power-down low must not wake
  task t_nopd;
    la <= 0;
    wr(`ADDR_WAKE_CONTROL, 32'h00000001);
    cyc(8);
    `CHK(wake, 1'b0)
    rd(`ADDR_WAKE_FLAGS);
    `CHK(rv, 32'h00000000)
    pd <= 1;
    cyc(2);
    `CHK(wake, 1'b1)
    wr(`ADDR_WAKE_CONTROL, 32'h00000000);
    wr(`ADDR_WAKE_FLAGS, 32'h00000000);
    wr(`ADDR_IRQ_STATUS, 32'h00000003);
  endtask
  // both pins at level l, only pin p enabled, polarity l for pin p
  task t_wake(input int p, input logic l);
    logic [31:0] pol, en;
    pol = {31'h0, l} << (4 + p);
    en = 32'h1 << p;
    la <= l;
    lb <= l;
    wr(`ADDR_WAKE_CONTROL, pol);
    cyc(8);
    `CHK(wake, 1'b0)
    wr(`ADDR_WAKE_CONTROL, pol | en);
    cyc(8);
    `CHK(wake, 1'b1)
    rd(`ADDR_WAKE_FLAGS);
    `CHK(rv, en)
    `CHK(irq, 1'b0)
    wr(`ADDR_IRQ_MASK, 32'h00000003);
    cyc(1);
    `CHK(irq, 1'b1)
    // the opposite level must not keep the wake up
    la <= ~l;
    lb <= ~l;
    cyc(8);
    `CHK(wake, 1'b0)
    wr(`ADDR_WAKE_CONTROL, pol);
    cyc(2);
    `CHK(wake, 1'b0)
    wr(`ADDR_WAKE_FLAGS, ~en);
    rd(`ADDR_WAKE_FLAGS);
    `CHK(rv, 32'h00000000)
    wr(`ADDR_IRQ_STATUS, en);
    cyc(1);
    `CHK(irq, 1'b0)
    wr(`ADDR_IRQ_MASK, 32'h00000000);
  endtask
  task finish_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ======================================================
  // main sequence and watchdog, well above the expected run
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1;
    t_reset;
    t_nopd;
    for (int p = 0; p < 2; p++)
      for (int l = 0; l < 2; l++)
        t_wake(p, l[0]);
    finish_test;
  end
  initial begin
    #500000;
    err_total++;
    finish_test;
  end
endmodule // ext_irq_wakeup_logic_tb
